// *** osc_ctrl_pkg.sv ***
// Summary of operation
// - current source field, read-only, eight encodings
// - writable next source, reset from configuration
// - lock bit plus honor config freezes source select, postscaler, vco divider, prescaler and multiplier, not reduction fields or trim
// - pll in-phase status from lock or timer
// - fail monitor sets fail flag, software clears
// - secondary oscillator enable follows its bit
// - switch request reads zero once switch finished
// - oscillator control writes need prior unlock sequence
// - unimplemented bits read zero, ignore writes
// - recover-on-irq makes interrupts clear reduction enable
// - reduction field divides processor clock by 2^n
// - reduction enable off forces one-to-one ratio
// - fast rc postscaler 1..64, code 7 is 256
// - vco divider 2, 4, reserved, 8
// - pll prescaler equals field plus two
// - feedback multiplier equals field plus two
// - signed trim field shifts fast rc frequency
// - instruction clock is oscillator clock divided by two
// - switching disabled freezes request bit at zero
// - switch to same source aborts, request clears
// - wait ten new-clock cycles, then change over
package osc_ctrl_pkg;

    // register byte offsets
    localparam logic [11:0] OFS_OSC_CONTROL   = 12'h000;
    localparam logic [11:0] OFS_CLOCK_DIVISOR = 12'h004;
    localparam logic [11:0] OFS_PLL_FEEDBACK  = 12'h008;
    localparam logic [11:0] OFS_FAST_RC_TUNE  = 12'h00c;
    localparam logic [11:0] OFS_UNLOCK        = 12'h010;

    // unlock keys, written in this order
    localparam logic [15:0] UNLOCK_KEY_FIRST  = 16'h0046;
    localparam logic [15:0] UNLOCK_KEY_SECOND = 16'h0057;

    // oscillator control field positions
    localparam int POS_CUR_SRC   = 12;
    localparam int POS_NEXT_SRC  = 8;
    localparam int POS_CFG_LOCK  = 7;
    localparam int POS_PLL_PHASE = 5;
    localparam int POS_FAIL      = 3;
    localparam int POS_SEC_OSC   = 1;
    localparam int POS_SWITCH    = 0;

    // clock divisor field positions
    localparam int POS_ROI       = 15;
    localparam int POS_REDUCE    = 12;
    localparam int POS_REDUCE_EN = 11;
    localparam int POS_FRC_POST  = 8;
    localparam int POS_VCO_DIV   = 6;
    localparam int POS_PRE_DIV   = 0;

    // reset values
    localparam logic [2:0] RST_REDUCE   = 3'h3;
    localparam logic [2:0] RST_FRC_POST = 3'h0;
    localparam logic [1:0] RST_VCO_DIV  = 2'h1;
    localparam logic [4:0] RST_PRE_DIV  = 5'h00;
    localparam logic [8:0] RST_FB_MULT  = 9'h030;
    localparam logic [5:0] RST_TRIM     = 6'h00;

    // new-clock cycles waited before change-over
    localparam logic [3:0] SWITCH_SETTLE_TICKS = 4'ha;

    // pll source codes
    localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;

    typedef enum logic [2:0] {
        SW_IDLE   = 3'b001,
        SW_WAIT   = 3'b010,
        SW_SETTLE = 3'b100
    } switch_state_t;

    // decoded clock settings handed to the analog side
    typedef struct packed {
        logic [8:0] fast_rc_divide;
        logic [3:0] vco_divide;
        logic [5:0] pre_divide;
        logic [9:0] fb_multiply;
        logic [5:0] fast_rc_trim;
    } clock_settings_t;

endpackage : osc_ctrl_pkg

// *** pulse_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module pulse_divider
    import osc_ctrl_pkg::*;
#(
    parameter int W = 7
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // count enable and terminal count
    input  wire logic         en,
    input  wire logic [W-1:0] limit,
    // one pulse per limit+1 enables
    output logic              pulse
);

    typedef struct packed {
        logic [W-1:0] count;
    } div_state_t;

    div_state_t s_reg;
    div_state_t s_next;

    // count enables, wrap at the limit
    always_comb begin
        s_next = s_reg;
        if (en) begin
            if (s_reg.count >= limit) begin
                s_next.count = '0;
            end else begin
                s_next.count = s_reg.count + W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pulse = en && (s_reg.count >= limit);

endmodule : pulse_divider
`default_nettype wire

// *** osc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl
    import osc_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // configuration bits; initial source sampled at reset, the other two used live
    input  wire logic [2:0]  initial_source_config,
    input  wire logic        lock_honor_config,
    input  wire logic        switch_enable_config,
    // analog oscillator and pll status
    input  wire logic        pll_enabled,
    input  wire logic        pll_locked,
    input  wire logic        pll_timer_expired,
    input  wire logic        new_source_ready,
    input  wire logic        new_clk_tick,
    input  wire logic        fail_detect,
    input  wire logic        irq_event,
    // oscillator control outputs
    output logic [2:0]       current_source_select,
    output logic [2:0]       switch_target,
    output logic             switch_busy,
    output logic             secondary_osc_enable,
    output clock_settings_t  settings,
    // clock enables
    output logic             periph_clk_en,
    output logic             cpu_clk_en
);

    typedef struct packed {
        logic [2:0]    cur_src;
        logic [2:0]    next_src;
        logic [2:0]    target;
        logic          cfg_lock;
        logic          pll_phase;
        logic          fail;
        logic          sec_osc;
        logic          switch_req;
        logic          recover_on_irq;
        logic [2:0]    reduce;
        logic          reduce_en;
        logic [2:0]    frc_post;
        logic [1:0]    vco_div;
        logic [4:0]    pre_div;
        logic [8:0]    fb_mult;
        logic [5:0]    trim;
        logic          key_seen;
        logic          armed;
        switch_state_t sw_state;
        logic [3:0]    ticks;
        logic          wr_pend;
        logic [11:0]   wr_addr;
        logic [31:0]   rdata;
    } ctrl_state_t;

    ctrl_state_t s_reg;
    ctrl_state_t s_next;
    logic        addr_phase;
    logic        locked;
    logic [15:0] wd;
    logic [15:0] rd_word;
    logic        cy_en;
    logic        doze_pulse;

    assign addr_phase = hsel && htrans[1] && hready;
    assign locked     = s_reg.cfg_lock && lock_honor_config;
    assign wd         = hwdata[15:0];

    // read word assembly, unimplemented bits zero
    always_comb begin
        rd_word = 16'h0000;
        if (haddr[11:0] == OFS_OSC_CONTROL) begin
            rd_word[POS_CUR_SRC +: 3]  = s_reg.cur_src;
            rd_word[POS_NEXT_SRC +: 3] = s_reg.next_src;
            rd_word[POS_CFG_LOCK]      = s_reg.cfg_lock;
            rd_word[POS_PLL_PHASE]     = s_reg.pll_phase;
            rd_word[POS_FAIL]          = s_reg.fail;
            rd_word[POS_SEC_OSC]       = s_reg.sec_osc;
            rd_word[POS_SWITCH]        = s_reg.switch_req;
        end else if (haddr[11:0] == OFS_CLOCK_DIVISOR) begin
            rd_word[POS_ROI]           = s_reg.recover_on_irq;
            rd_word[POS_REDUCE +: 3]   = s_reg.reduce;
            rd_word[POS_REDUCE_EN]     = s_reg.reduce_en;
            rd_word[POS_FRC_POST +: 3] = s_reg.frc_post;
            rd_word[POS_VCO_DIV +: 2]  = s_reg.vco_div;
            rd_word[POS_PRE_DIV +: 5]  = s_reg.pre_div;
        end else if (haddr[11:0] == OFS_PLL_FEEDBACK) begin
            rd_word[8:0] = s_reg.fb_mult;
        end else if (haddr[11:0] == OFS_FAST_RC_TUNE) begin
            rd_word[5:0] = s_reg.trim;
        end else if (haddr[11:0] == OFS_UNLOCK) begin
            rd_word[0] = s_reg.armed;
        end
    end

    // bus writes, then hardware events, then the switch sequencer, then fail detection
    always_comb begin
        s_next = s_reg;
        // address phase capture and registered read data
        s_next.wr_pend = addr_phase && hwrite;
        if (addr_phase) begin
            s_next.wr_addr = haddr[11:0];
        end
        if (addr_phase && !hwrite) begin
            s_next.rdata = {16'h0000, rd_word};
        end
        // data phase of a write
        if (s_reg.wr_pend) begin
            if (s_reg.wr_addr == OFS_UNLOCK) begin
                s_next.key_seen = (wd == UNLOCK_KEY_FIRST);
                s_next.armed    = s_reg.key_seen && (wd == UNLOCK_KEY_SECOND);
            end else if (s_reg.wr_addr == OFS_OSC_CONTROL) begin
                s_next.key_seen = 1'b0;
                s_next.armed    = 1'b0; // one write per unlock
                if (s_reg.armed) begin
                    s_next.sec_osc = wd[POS_SEC_OSC];
                    if (!wd[POS_FAIL]) begin
                        s_next.fail = 1'b0; // clear on zero only
                    end
                    if (!locked) begin
                        s_next.next_src = wd[POS_NEXT_SRC +: 3];
                        s_next.cfg_lock = wd[POS_CFG_LOCK];
                        if (wd[POS_SWITCH] && switch_enable_config) begin
                            s_next.switch_req = 1'b1;
                        end
                    end
                end
            end else if (s_reg.wr_addr == OFS_CLOCK_DIVISOR) begin
                s_next.recover_on_irq       = wd[POS_ROI];
                s_next.reduce    = wd[POS_REDUCE +: 3];
                s_next.reduce_en = wd[POS_REDUCE_EN];
                if (!locked) begin
                    s_next.frc_post = wd[POS_FRC_POST +: 3];
                    s_next.vco_div  = wd[POS_VCO_DIV +: 2];
                    s_next.pre_div  = wd[POS_PRE_DIV +: 5];
                end
            end else if (s_reg.wr_addr == OFS_PLL_FEEDBACK) begin
                if (!locked) begin
                    s_next.fb_mult = wd[8:0];
                end
            end else if (s_reg.wr_addr == OFS_FAST_RC_TUNE) begin
                s_next.trim = wd[5:0];
            end
        end
        // interrupt restores one-to-one ratio
        if (irq_event && s_reg.recover_on_irq) begin
            s_next.reduce_en = 1'b0;
        end
        // pll in-phase status
        s_next.pll_phase = pll_enabled && (pll_locked || pll_timer_expired);
        // switch sequencer
        case (s_reg.sw_state)
            SW_IDLE: begin
                if (s_reg.switch_req) begin
                    if (s_reg.next_src == s_reg.cur_src) begin
                        s_next.switch_req = 1'b0; // redundant switch aborts
                    end else begin
                        s_next.target    = s_reg.next_src;
                        s_next.fail      = 1'b0;
                        s_next.pll_phase = 1'b0;
                        s_next.sw_state  = SW_WAIT;
                    end
                end
            end
            SW_WAIT: begin
                if (new_source_ready) begin
                    s_next.ticks    = 4'h0;
                    s_next.sw_state = SW_SETTLE;
                end
            end
            SW_SETTLE: begin
                if (new_clk_tick) begin
                    if (s_reg.ticks == SWITCH_SETTLE_TICKS - 4'h1) begin
                        s_next.cur_src    = s_reg.target;
                        s_next.switch_req = 1'b0;
                        s_next.sw_state   = SW_IDLE;
                    end else begin
                        s_next.ticks = s_reg.ticks + 4'h1;
                    end
                end
            end
            default: begin
                s_next.sw_state = SW_IDLE;
            end
        endcase
        // a detected failure wins over any clear
        if (fail_detect) begin
            s_next.fail = 1'b1;
        end
    end

    // state register, sources from configuration at reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg           <= '0;
            s_reg.cur_src   <= initial_source_config;
            s_reg.next_src  <= initial_source_config;
            s_reg.target    <= initial_source_config;
            s_reg.reduce    <= RST_REDUCE;
            s_reg.frc_post  <= RST_FRC_POST;
            s_reg.vco_div   <= RST_VCO_DIV;
            s_reg.pre_div   <= RST_PRE_DIV;
            s_reg.fb_mult   <= RST_FB_MULT;
            s_reg.trim      <= RST_TRIM;
            s_reg.sw_state  <= SW_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // instruction clock at half the oscillator rate
    pulse_divider #(
        .W     (1)
    ) u_cycle_div (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (1'b1),
        .limit (1'b1),
        .pulse (cy_en)
    );

    // processor reduction by two to the field value
    pulse_divider #(
        .W     (7)
    ) u_doze_div (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (cy_en),
        .limit (7'((8'h01 << s_reg.reduce) - 8'h01)),
        .pulse (doze_pulse)
    );

    assign periph_clk_en = cy_en;
    assign cpu_clk_en    = s_reg.reduce_en ? doze_pulse : cy_en;

    // decoded divider and multiplier settings
    always_comb begin
        settings.fast_rc_divide = (s_reg.frc_post == 3'h7) ? 9'h100 :
                                  9'(9'h001 << s_reg.frc_post);
        case (s_reg.vco_div)
            2'h0:    settings.vco_divide = 4'h2;
            2'h1:    settings.vco_divide = 4'h4;
            2'h3:    settings.vco_divide = 4'h8;
            default: settings.vco_divide = 4'h0;
        endcase
        settings.pre_divide   = {1'b0, s_reg.pre_div} + 6'h02;
        settings.fb_multiply  = {1'b0, s_reg.fb_mult} + 10'h002;
        settings.fast_rc_trim = s_reg.trim;
    end

    assign current_source_select = s_reg.cur_src;
    assign switch_target         = s_reg.target;
    assign switch_busy           = (s_reg.sw_state != SW_IDLE);
    assign secondary_osc_enable  = s_reg.sec_osc;
    assign hreadyout             = 1'b1;
    assign hresp                 = 1'b0;
    assign hrdata                = s_reg.rdata;

    // checks
    a_upper_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
        hrdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_fail_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        fail_detect |=> s_reg.fail)
        else $error("fail flag not set by detection");
    a_irq_recover: assert property (@(posedge clk) disable iff (!rst_n)
        irq_event && s_reg.recover_on_irq |=> !s_reg.reduce_en)
        else $error("interrupt did not clear reduction enable");
    a_no_switch_dis: assert property (@(posedge clk) disable iff (!rst_n)
        !switch_enable_config && !s_reg.switch_req |=> !s_reg.switch_req)
        else $error("request set while switching disabled");
    a_redundant_abort: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.sw_state == SW_IDLE && s_reg.switch_req && s_reg.next_src == s_reg.cur_src
        |=> !s_reg.switch_req && $stable(s_reg.cur_src))
        else $error("redundant switch not aborted");
    a_switch_settle: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.sw_state == SW_SETTLE && new_clk_tick && s_reg.ticks == 4'h9
        |=> s_reg.cur_src == $past(s_reg.target) && !s_reg.switch_req)
        else $error("change-over not after ten ticks");
    a_settle_early: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.sw_state == SW_SETTLE && s_reg.ticks < 4'h9 |=> $stable(s_reg.cur_src))
        else $error("source changed before ten ticks");
    a_unlock_needed: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.wr_pend && s_reg.wr_addr == OFS_OSC_CONTROL && !s_reg.armed
        |=> $stable(s_reg.next_src) && $stable(s_reg.sec_osc))
        else $error("control written without unlock");
    a_lock_freeze: assert property (@(posedge clk) disable iff (!rst_n)
        locked && s_reg.wr_pend && s_reg.wr_addr == OFS_PLL_FEEDBACK
        |=> $stable(s_reg.fb_mult))
        else $error("locked feedback value changed");
    a_phase_status: assert property (@(posedge clk) disable iff (!rst_n)
        !pll_enabled |=> !s_reg.pll_phase)
        else $error("in-phase set while pll disabled");
    a_cycle_half: assert property (@(posedge clk) disable iff (!rst_n)
        cy_en |=> !cy_en ##1 cy_en)
        else $error("instruction enable not every second cycle");
    a_ratio_one: assert property (@(posedge clk) disable iff (!rst_n)
        !s_reg.reduce_en |-> cpu_clk_en == periph_clk_en)
        else $error("ratio not one-to-one");

    // bus answer, status, sequencer, lock and clock enable checks
    a_bus_okay: assert property (@(posedge clk) disable iff (!rst_n)
        hreadyout && !hresp)
        else $error("bus answer not okay");
    a_phase_set: assert property (@(posedge clk) disable iff (!rst_n)
        pll_enabled && pll_locked && !s_reg.switch_req |=> s_reg.pll_phase)
        else $error("in-phase not set");
    a_cur_src_hold: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.sw_state != SW_SETTLE |=> $stable(s_reg.cur_src))
        else $error("current source changed outside switch");
    a_switch_start: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.sw_state == SW_IDLE && s_reg.switch_req && s_reg.next_src != s_reg.cur_src
        |=> switch_busy && switch_target == $past(s_reg.next_src))
        else $error("valid switch not started");
    a_busy_request: assert property (@(posedge clk) disable iff (!rst_n)
        switch_busy |-> s_reg.switch_req)
        else $error("request low while busy");
    a_wait_ready: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.sw_state == SW_WAIT && !new_source_ready |=> s_reg.sw_state == SW_WAIT)
        else $error("left wait before source ready");
    a_lock_divisor: assert property (@(posedge clk) disable iff (!rst_n)
        locked && s_reg.wr_pend && s_reg.wr_addr == OFS_CLOCK_DIVISOR
        |=> $stable(s_reg.vco_div) && $stable(s_reg.pre_div))
        else $error("locked divisor fields changed");
    a_lock_bit_hold: assert property (@(posedge clk) disable iff (!rst_n)
        locked |=> s_reg.cfg_lock)
        else $error("lock bit cleared while locked");
    a_fail_no_set: assert property (@(posedge clk) disable iff (!rst_n)
        !fail_detect && !s_reg.fail |=> !s_reg.fail)
        else $error("fail flag set without detection");
    a_cpu_in_periph: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_clk_en |-> periph_clk_en)
        else $error("processor enable off the instruction grid");

endmodule : osc_ctrl
`default_nettype wire

// *** oscillator_clock_control_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module oscillator_clock_control_regs_bench
    import osc_ctrl_pkg::*;
;
    // bus, configuration and status stimulus
    logic            clk, rst_n, hsel, hwrite, hreadyout, hresp;
    logic            lk_honor, sw_en, pll_en, pll_lk, pll_tmr;
    logic            src_rdy, tick, fail, irq, busy, sec_en, per_en, cpu_en;
    logic [1:0]      htrans;
    logic [2:0]      hsize, init_src, cur_src, sw_tgt;
    logic [31:0]     haddr, hwdata, hrdata;
    wire logic       hready;
    clock_settings_t settings;
    int              err_total, comparisons;

    // single slave: its ready is the bus ready
    assign hready = hreadyout;

    osc_ctrl osc_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .initial_source_config(init_src), .lock_honor_config(lk_honor),
        .switch_enable_config(sw_en), .pll_enabled(pll_en), .pll_locked(pll_lk),
        .pll_timer_expired(pll_tmr), .new_source_ready(src_rdy), .new_clk_tick(tick),
        .fail_detect(fail), .irq_event(irq), .current_source_select(cur_src),
        .switch_target(sw_tgt), .switch_busy(busy), .secondary_osc_enable(sec_en),
        .settings(settings), .periph_clk_en(per_en), .cpu_clk_en(cpu_en)
    );

    // 100 ns clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    // verdict and end of run
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // oscillator control word as it should read back
    function automatic logic [31:0] osc(input logic [2:0] c, n, input logic l, p, f, s, r);
        return {16'h0, 1'b0, c, 1'b0, n, l, 1'b0, p, 1'b0, f, 1'b0, s, r};
    endfunction : osc

    // bounded wait for ready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            if (n == 50) begin
                err_total++;
                summarize();
            end
            n++;
            @(posedge clk);
        end
    endtask : wait_rdy

    // one single word transfer, address phase then data phase
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'h2;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : xfer

    task automatic wrt(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask : wrt

    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        xfer(1'b0, a, 32'h0, v);
        check(what, 64'(v), 64'(exp));
    endtask : rdc

    // unlock keys, then the armed write to oscillator control
    task automatic owr(input logic [31:0] d);
        wrt(OFS_UNLOCK, 32'h46);
        wrt(OFS_UNLOCK, 32'h57);
        wrt(OFS_OSC_CONTROL, d);
    endtask : owr

    task automatic wait_busy(input logic v);
        int n;
        n = 0;
        while (busy !== v) begin
            if (n == 100) begin
                err_total++;
                summarize();
            end
            n++;
            @(posedge clk);
        end
    endtask : wait_busy

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : do_reset

    task automatic t_reset;
        rdc("osc rst", OFS_OSC_CONTROL, osc(3'h2, 3'h2, 0, 0, 0, 0, 0));
        rdc("cdiv rst", OFS_CLOCK_DIVISOR, 32'h3040);
        rdc("fbd rst", OFS_PLL_FEEDBACK, 32'h0030);
        rdc("trim rst", OFS_FAST_RC_TUNE, 32'h0);
        check("set rst", 64'(settings), {29'h0, 9'd1, 4'd4, 6'd2, 10'd50, 6'd0});
    endtask : t_reset

    task automatic t_fields;
        wrt(OFS_CLOCK_DIVISOR, 32'hffffffff);
        wrt(OFS_PLL_FEEDBACK, 32'hffffffff);
        wrt(OFS_FAST_RC_TUNE, 32'hffffffff);
        wrt(12'h020, 32'hffffffff);
        rdc("cdiv ones", OFS_CLOCK_DIVISOR, 32'hffdf);
        rdc("fbd ones", OFS_PLL_FEEDBACK, 32'h01ff);
        rdc("trim ones", OFS_FAST_RC_TUNE, 32'h003f);
        rdc("unmapped", 12'h020, 32'h0);
        check("resp", 64'(hresp), 64'h0);
        check("set max", 64'(settings), {29'h0, 9'd256, 4'd8, 6'd33, 10'd513, 6'h3f});
        wrt(OFS_CLOCK_DIVISOR, 32'h0080);
        rdc("vco rsvd", OFS_CLOCK_DIVISOR, 32'h0080);
        check("set rsvd", 64'(settings), {29'h0, 9'd1, 4'd0, 6'd2, 10'd513, 6'h3f});
    endtask : t_fields

    task automatic t_protect;
        wrt(OFS_OSC_CONTROL, 32'h0402);
        rdc("no unlock", OFS_OSC_CONTROL, osc(3'h2, 3'h2, 0, 0, 0, 0, 0));
        owr(32'hfc56);
        rdc("unlocked", OFS_OSC_CONTROL, osc(3'h2, 3'h4, 0, 0, 0, 1, 0));
        check("sec osc", 64'(sec_en), 64'h1);
        wrt(OFS_OSC_CONTROL, 32'h0000);
        rdc("one shot", OFS_OSC_CONTROL, osc(3'h2, 3'h4, 0, 0, 0, 1, 0));
    endtask : t_protect

    // enable, lock, timer patterns and the in-phase bit each should give
    task automatic t_phase;
        for (int i = 0; i < 4; i++) begin
            {pll_en, pll_lk, pll_tmr} <= 3'(12'b110_101_100_011 >> (9 - 3 * i));
            repeat (3) @(posedge clk);
            rdc("phase", OFS_OSC_CONTROL, osc(3'h2, 3'h4, 0, i < 2, 0, 1, 0));
        end
        {pll_en, pll_lk, pll_tmr} <= 3'b000;
    endtask : t_phase

    task automatic t_fail;
        fail <= 1'b1;
        @(posedge clk);
        fail <= 1'b0;
        rdc("fail set", OFS_OSC_CONTROL, osc(3'h2, 3'h4, 0, 0, 1, 1, 0));
        owr(32'h040a);
        rdc("fail w1", OFS_OSC_CONTROL, osc(3'h2, 3'h4, 0, 0, 1, 1, 0));
        owr(32'h0402);
        rdc("fail w0", OFS_OSC_CONTROL, osc(3'h2, 3'h4, 0, 0, 0, 1, 0));
    endtask : t_fail

    task automatic t_same;
        owr(32'h0203);
        repeat (3) @(posedge clk);
        rdc("abort", OFS_OSC_CONTROL, osc(3'h2, 3'h2, 0, 0, 0, 1, 0));
        check("abort busy", 64'(busy), 64'h0);
    endtask : t_same

    // switch to low-power rc, not between the two multiplier sources
    task automatic t_switch;
        owr(32'h0503);
        wait_busy(1'b1);
        check("target", 64'(sw_tgt), 64'h5);
        src_rdy <= 1'b1;
        @(posedge clk); // sequencer leaves the wait state first
        for (int i = 0; i < 10; i++) begin
            if (i == 9) check("cur early", 64'(cur_src), 64'h2);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
        check("cur new", 64'(cur_src), 64'h5);
        check("busy end", 64'(busy), 64'h0);
        rdc("sw done", OFS_OSC_CONTROL, osc(3'h5, 3'h5, 0, 0, 0, 1, 0));
        src_rdy <= 1'b0;
    endtask : t_switch

    // count enable pulses over a whole number of reduction periods
    task automatic count_en(input int ep, input int ec);
        int p;
        int c;
        p = 0;
        c = 0;
        repeat (4) @(posedge clk);
        repeat (64) begin
            @(posedge clk);
            p += int'(per_en);
            c += int'(cpu_en);
        end
        check("periph cnt", 64'(p), 64'(ep));
        check("cpu cnt", 64'(c), 64'(ec));
    endtask : count_en

    task automatic t_reduce;
        wrt(OFS_CLOCK_DIVISOR, 32'h3800);
        count_en(32, 4);
        wrt(OFS_CLOCK_DIVISOR, 32'h3000);
        count_en(32, 32);
        wrt(OFS_CLOCK_DIVISOR, 32'h8800);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        rdc("roi on", OFS_CLOCK_DIVISOR, 32'h8000);
        wrt(OFS_CLOCK_DIVISOR, 32'h0800);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        rdc("roi off", OFS_CLOCK_DIVISOR, 32'h0800);
    endtask : t_reduce

    task automatic t_lock;
        owr(32'h0582);
        rdc("lock on", OFS_OSC_CONTROL, osc(3'h5, 3'h5, 1, 0, 0, 1, 0));
        owr(32'h0002);
        rdc("lock hold", OFS_OSC_CONTROL, osc(3'h5, 3'h5, 1, 0, 0, 1, 0));
        wrt(OFS_CLOCK_DIVISOR, 32'h0700);
        rdc("cdiv lock", OFS_CLOCK_DIVISOR, 32'h0000);
        wrt(OFS_PLL_FEEDBACK, 32'h0001);
        rdc("fbd lock", OFS_PLL_FEEDBACK, 32'h01ff);
    endtask : t_lock

    task automatic t_noswitch;
        owr(32'h0301);
        repeat (3) @(posedge clk);
        rdc("no switch", OFS_OSC_CONTROL, osc(3'h2, 3'h3, 0, 0, 0, 0, 0));
        check("no busy", 64'(busy), 64'h0);
    endtask : t_noswitch

    // main sequence
    initial begin
        err_total = 0;
        comparisons = 0;
        rst_n = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        init_src = 3'h2;
        {lk_honor, sw_en} = 2'b11;
        {pll_en, pll_lk, pll_tmr, src_rdy, tick, fail, irq} = '0;
        do_reset();
        t_reset();
        t_fields();
        t_protect();
        t_phase();
        t_fail();
        t_same();
        t_switch();
        t_reduce();
        t_lock();
        sw_en <= 1'b0;
        do_reset();
        t_noswitch();
        summarize();
    end
endmodule : oscillator_clock_control_regs_bench
`default_nettype wire
